/* design/rtcc_defs.vh */
// rtcc_defs.vh: offsets, fields, reset values and limits of the rtc core
// assumes inclusion by bare name from design and bench files
`ifndef RTCC_DEFS_VH
`define RTCC_DEFS_VH
// indirect addresses
`define RTCC_A_RSVD 5'h00
`define RTCC_A_FRAC 5'h01
`define RTCC_A_SEC 5'h02
`define RTCC_A_MIN 5'h03
`define RTCC_A_HOUR 5'h04
`define RTCC_A_WDAY 5'h05
`define RTCC_A_MDAY 5'h06
`define RTCC_A_MON 5'h07
`define RTCC_A_YEAR 5'h08
`define RTCC_A_IVAL 5'h09
`define RTCC_A_ALARM_ONE_HZ_MATCH 5'h0a
`define RTCC_A_ALARM_M_MATCH 5'h0b
`define RTCC_A_ALARM_H_MATCH 5'h0c
`define RTCC_A_AL_WDAY 5'h0d
`define RTCC_A_AL_MDAY 5'h0e
`define RTCC_A_CAL 5'h0f
`define RTCC_A_XOFS 5'h10
`define RTCC_A_XLO 5'h11
`define RTCC_A_XHI 5'h12
// pointer fields
`define RTCC_PTR_DIR 7
// unlock key
`define RTCC_KEY_TIME 8'hea
// clock_config_byte fields
`define RTCC_CFG_BASE_LO 0
`define RTCC_CFG_BASE_HI 1
`define RTCC_CFG_IVAL_EN 2
`define RTCC_CFG_INT_EN 3
`define RTCC_CFG_IFLAG 4
`define RTCC_CFG_AFLAG 5
// interval base codes
`define RTCC_BASE_FRAC 2'h0
`define RTCC_BASE_SEC 2'h1
`define RTCC_BASE_MIN 2'h2
`define RTCC_BASE_HOUR 2'h3
// alarm enable bit positions
`define RTCC_EN_SEC 0
`define RTCC_EN_MIN 1
`define RTCC_EN_HOUR 2
`define RTCC_EN_WDAY 3
`define RTCC_EN_MDAY 4
// counter limits and reset values
`define RTCC_FRAC_MAX 8'h7f
`define RTCC_SEC_MAX 8'h3b
`define RTCC_HOUR_MAX 8'h17
`define RTCC_WDAY_MAX 8'h06
`define RTCC_MON_MAX 8'h0c
`define RTCC_ONE 8'h01
`define RTCC_RST_ZERO 8'h00
`define RTCC_RST_MDAY 8'h01
`define RTCC_RST_MON 8'h01
`endif

/* design/rtcc_core.v */
// rtcc_core.v: calendar, interval timer, alarm and indirect register file
// assumes a 20 MHz CLK and a 1/128 s calibrated tick pin from the
// crystal domain; the sfr strobes come from logic on CLK
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_defs.vh"
module rtcc_core (
   // clock and reset
   input wire CLK,
   input wire RST,
   // calibrated 1/128 s tick from the crystal domain
   input wire TICK_128,
   // sfr writes
   input wire [7:0] SFR_WDATA,
   input wire PTR_WE,
   input wire DATA_WE,
   input wire KEY_WE,
   input wire CFG_WE,
   input wire ALEN_WE,
   // sfr readback
   output wire [7:0] PTR_RDATA,
   output reg [7:0] DATA_RDATA,
   output reg [7:0] KEY_RDATA,
   output wire [7:0] CFG_RDATA,
   output wire [7:0] ALEN_RDATA,
   // pending clock interrupt request
   output wire RTC_PEND
);
   // synchroniser and timekeeping
   reg tick_s1;
   reg tick_s2;
   reg tick_s3;
   reg [7:0] frac;
   reg [7:0] sec;
   reg [7:0] min;
   reg [7:0] hour;
   reg [7:0] wday;
   reg [7:0] mday;
   reg [7:0] mon;
   reg [7:0] year;
   // storage behind the indirect window
   reg [7:0] ival_tgt;
   reg [7:0] ival_cnt;
   reg [7:0] alarm_one_hz_match;
   reg [7:0] alarm_m_match;
   reg [7:0] alarm_h_match;
   reg [7:0] al_wday;
   reg [7:0] al_mday;
   reg [7:0] cal_cfg;
   reg [7:0] xofs;
   reg [7:0] xlo;
   reg [7:0] xhi;
   // pointer, config and helpers
   reg [4:0] ptr_addr;
   reg ptr_dir;
   reg rd_pend;
   reg [1:0] base_sel;
   reg ival_en;
   reg int_en;
   reg ival_flag;
   reg alarm_flag;
   reg [4:0] al_en;
   reg sec_upd;
   reg [7:0] rd_mux;
   reg [7:0] mlen;
   // carries and strobes
   wire tick;
   wire c_sec;
   wire c_min;
   wire c_hour;
   wire c_day;
   wire c_mon;
   wire c_year;
   wire unlocked;
   wire wr;
   wire base_tick;
   wire ival_hit;
   wire al_any;
   wire al_match;
   wire [7:0] ival_next;
   wire [4:0] al_eq;
   wire [39:0] al_now;
   wire [39:0] al_ref;
   genvar gi;

   // third flop only feeds the edge detect; the first stays private
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         tick_s1 <= 1'b0;
         tick_s2 <= 1'b0;
         tick_s3 <= 1'b0;
      end else begin
         tick_s1 <= TICK_128;
         tick_s2 <= tick_s1;
         tick_s3 <= tick_s2;
      end
   end
   assign tick = tick_s2 & ~tick_s3;

   // carry chain from the current counts
   assign c_sec = tick & (frac == `RTCC_FRAC_MAX);
   assign c_min = c_sec & (sec == `RTCC_SEC_MAX);
   assign c_hour = c_min & (min == `RTCC_SEC_MAX);
   assign c_day = c_hour & (hour == `RTCC_HOUR_MAX);
   assign c_mon = c_day & (mday >= mlen);
   assign c_year = c_mon & (mon >= `RTCC_MON_MAX);

   // month length; every fourth year is a leap year
   // a month code of 0 or above 12 runs as a 31-day month
   always @* begin
      case (mon)
         8'h02: mlen = (year[1:0] == 2'h0) ? 8'h1d : 8'h1c;
         8'h04, 8'h06, 8'h09, 8'h0b: mlen = 8'h1e;
         default: mlen = 8'h1f;
      endcase
   end

   assign unlocked = (KEY_RDATA == `RTCC_KEY_TIME);
   assign wr = DATA_WE & ptr_dir;

   // key must be the write just before the data write
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         KEY_RDATA <= `RTCC_RST_ZERO;
      end else if (KEY_WE) begin
         KEY_RDATA <= SFR_WDATA;
      end else if (PTR_WE | DATA_WE | CFG_WE | ALEN_WE) begin
         KEY_RDATA <= `RTCC_RST_ZERO;
      end
   end

   // protected counters: a keyed write beats the count in that cycle
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         frac <= `RTCC_RST_ZERO;
         sec <= `RTCC_RST_ZERO;
         min <= `RTCC_RST_ZERO;
         hour <= `RTCC_RST_ZERO;
      end else begin
         if (wr & unlocked & (ptr_addr == `RTCC_A_FRAC)) begin
            frac <= SFR_WDATA;
         end else if (tick) begin
            frac <= c_sec ? `RTCC_RST_ZERO : frac + `RTCC_ONE;
         end
         if (wr & unlocked & (ptr_addr == `RTCC_A_SEC)) begin
            sec <= SFR_WDATA;
         end else if (c_sec) begin
            sec <= c_min ? `RTCC_RST_ZERO : sec + `RTCC_ONE;
         end
         if (wr & unlocked & (ptr_addr == `RTCC_A_MIN)) begin
            min <= SFR_WDATA;
         end else if (c_min) begin
            min <= c_hour ? `RTCC_RST_ZERO : min + `RTCC_ONE;
         end
         if (wr & unlocked & (ptr_addr == `RTCC_A_HOUR)) begin
            hour <= SFR_WDATA;
         end else if (c_hour) begin
            hour <= c_day ? `RTCC_RST_ZERO : hour + `RTCC_ONE;
         end
      end
   end

   // calendar counters need no key
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         wday <= `RTCC_RST_ZERO;
         mday <= `RTCC_RST_MDAY;
         mon <= `RTCC_RST_MON;
         year <= `RTCC_RST_ZERO;
      end else begin
         if (wr & (ptr_addr == `RTCC_A_WDAY)) begin
            wday <= SFR_WDATA;
         end else if (c_day) begin
            wday <= (wday >= `RTCC_WDAY_MAX) ? `RTCC_RST_ZERO :
                    wday + `RTCC_ONE;
         end
         if (wr & (ptr_addr == `RTCC_A_MDAY)) begin
            mday <= SFR_WDATA;
         end else if (c_day) begin
            mday <= c_mon ? `RTCC_RST_MDAY : mday + `RTCC_ONE;
         end
         if (wr & (ptr_addr == `RTCC_A_MON)) begin
            mon <= SFR_WDATA;
         end else if (c_mon) begin
            mon <= c_year ? `RTCC_RST_MON : mon + `RTCC_ONE;
         end
         if (wr & (ptr_addr == `RTCC_A_YEAR)) begin
            year <= SFR_WDATA;
         end else if (c_year) begin
            year <= year + `RTCC_ONE;
         end
      end
   end

   // plain and protected storage registers
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         ival_tgt <= `RTCC_RST_ZERO;
         alarm_one_hz_match <= `RTCC_RST_ZERO;
         alarm_m_match <= `RTCC_RST_ZERO;
         alarm_h_match <= `RTCC_RST_ZERO;
         al_wday <= `RTCC_RST_ZERO;
         al_mday <= `RTCC_RST_ZERO;
         cal_cfg <= `RTCC_RST_ZERO;
         xofs <= `RTCC_RST_ZERO;
         xlo <= `RTCC_RST_ZERO;
         xhi <= `RTCC_RST_ZERO;
      end else if (wr) begin
         case (ptr_addr)
            `RTCC_A_IVAL: ival_tgt <= SFR_WDATA;
            `RTCC_A_ALARM_ONE_HZ_MATCH: alarm_one_hz_match <= SFR_WDATA;
            `RTCC_A_ALARM_M_MATCH: alarm_m_match <= SFR_WDATA;
            `RTCC_A_ALARM_H_MATCH: alarm_h_match <= SFR_WDATA;
            `RTCC_A_AL_WDAY: al_wday <= SFR_WDATA;
            `RTCC_A_AL_MDAY: al_mday <= SFR_WDATA;
            `RTCC_A_CAL: if (unlocked) cal_cfg <= SFR_WDATA;
            `RTCC_A_XOFS: if (unlocked) xofs <= SFR_WDATA;
            `RTCC_A_XLO: if (unlocked) xlo <= SFR_WDATA;
            `RTCC_A_XHI: if (unlocked) xhi <= SFR_WDATA;
            default: ;
         endcase
      end
   end

   // read path of the indirect window
   always @* begin
      case (ptr_addr)
         `RTCC_A_FRAC: rd_mux = frac;
         `RTCC_A_SEC: rd_mux = sec;
         `RTCC_A_MIN: rd_mux = min;
         `RTCC_A_HOUR: rd_mux = hour;
         `RTCC_A_WDAY: rd_mux = wday;
         `RTCC_A_MDAY: rd_mux = mday;
         `RTCC_A_MON: rd_mux = mon;
         `RTCC_A_YEAR: rd_mux = year;
         `RTCC_A_IVAL: rd_mux = ival_tgt;
         `RTCC_A_ALARM_ONE_HZ_MATCH: rd_mux = alarm_one_hz_match;
         `RTCC_A_ALARM_M_MATCH: rd_mux = alarm_m_match;
         `RTCC_A_ALARM_H_MATCH: rd_mux = alarm_h_match;
         `RTCC_A_AL_WDAY: rd_mux = al_wday;
         `RTCC_A_AL_MDAY: rd_mux = al_mday;
         `RTCC_A_CAL: rd_mux = cal_cfg;
         `RTCC_A_XOFS: rd_mux = xofs;
         `RTCC_A_XLO: rd_mux = xlo;
         `RTCC_A_XHI: rd_mux = xhi;
         default: rd_mux = `RTCC_RST_ZERO;
      endcase
   end

   // pointer write with direction clear copies the register one
   // cycle later, so the copy sees the newly loaded address
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         ptr_addr <= 5'h00;
         ptr_dir <= 1'b0;
         rd_pend <= 1'b0;
         DATA_RDATA <= `RTCC_RST_ZERO;
      end else begin
         if (PTR_WE) begin
            ptr_addr <= SFR_WDATA[4:0];
            ptr_dir <= SFR_WDATA[`RTCC_PTR_DIR];
         end
         rd_pend <= PTR_WE & ~SFR_WDATA[`RTCC_PTR_DIR];
         if (DATA_WE) begin
            DATA_RDATA <= SFR_WDATA;
         end else if (rd_pend) begin
            DATA_RDATA <= rd_mux;
         end
      end
   end
   assign PTR_RDATA = {ptr_dir, 2'h0, ptr_addr};

   // interval timer on the selected timebase
   // a target of zero only hits when the count wraps, after 256 events
   assign base_tick = (base_sel == `RTCC_BASE_FRAC) ? tick :
                      (base_sel == `RTCC_BASE_SEC) ? c_sec :
                      (base_sel == `RTCC_BASE_MIN) ? c_min : c_hour;
   assign ival_next = ival_cnt + `RTCC_ONE;
   assign ival_hit = ival_en & base_tick & (ival_next == ival_tgt);

   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         ival_cnt <= `RTCC_RST_ZERO;
      end else if (~ival_en) begin
         ival_cnt <= `RTCC_RST_ZERO;
      end else if (base_tick) begin
         ival_cnt <= ival_hit ? `RTCC_RST_ZERO : ival_next;
      end
   end

   // alarm looks once per second update, one cycle after it settles
   // one compare per alarm field; a disabled field reads as a match
   assign al_now = {mday, wday, hour, min, sec};
   assign al_ref = {al_mday, al_wday, alarm_h_match, alarm_m_match, alarm_one_hz_match};
   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_alarm
         assign al_eq[gi] = ~al_en[gi] |
                            (al_now[8*gi+:8] == al_ref[8*gi+:8]);
      end
   endgenerate
   assign al_any = |al_en;
   assign al_match = al_any & (al_eq == 5'h1f);

   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         sec_upd <= 1'b0;
      end else begin
         sec_upd <= c_sec;
      end
   end

   // config byte: flags cleared by writing zero, a new event wins
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         base_sel <= 2'h0;
         ival_en <= 1'b0;
         int_en <= 1'b0;
         ival_flag <= 1'b0;
         alarm_flag <= 1'b0;
         al_en <= 5'h00;
      end else begin
         if (CFG_WE) begin
            base_sel <= SFR_WDATA[`RTCC_CFG_BASE_HI:`RTCC_CFG_BASE_LO];
            ival_en <= SFR_WDATA[`RTCC_CFG_IVAL_EN];
            int_en <= SFR_WDATA[`RTCC_CFG_INT_EN];
         end
         if (ival_hit) begin
            ival_flag <= 1'b1;
         end else if (CFG_WE & ~SFR_WDATA[`RTCC_CFG_IFLAG]) begin
            ival_flag <= 1'b0;
         end
         if (sec_upd & al_match) begin
            alarm_flag <= 1'b1;
         end else if (CFG_WE & ~SFR_WDATA[`RTCC_CFG_AFLAG]) begin
            alarm_flag <= 1'b0;
         end
         if (ALEN_WE) begin
            al_en <= SFR_WDATA[4:0];
         end
      end
   end

   assign CFG_RDATA = {2'h0, alarm_flag, ival_flag, int_en, ival_en,
                       base_sel};
   assign ALEN_RDATA = {3'h0, al_en};
   // level request; it stays up until software clears both flags or int_en
   assign RTC_PEND = int_en & (ival_flag | alarm_flag);
endmodule
`default_nettype wire

/* verif/rtcc_sva.sv */
// rtcc_sva.sv: port assertions for rtcc_core
// assumes rising CLK and an active high async RST
`timescale 1ns/1ps
`default_nettype none
module rtcc_sva (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // sfr writes
   input wire logic [7:0] SFR_WDATA,
   input wire logic PTR_WE,
   input wire logic DATA_WE,
   input wire logic KEY_WE,
   input wire logic CFG_WE,
   input wire logic ALEN_WE,
   // readback and request
   input wire logic [7:0] PTR_RDATA,
   input wire logic [7:0] DATA_RDATA,
   input wire logic [7:0] KEY_RDATA,
   input wire logic [7:0] CFG_RDATA,
   input wire logic [7:0] ALEN_RDATA,
   input wire logic RTC_PEND
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   chk_pend_level: assert property (
      RTC_PEND == (CFG_RDATA[3] & (CFG_RDATA[4] | CFG_RDATA[5])))
      else $error("pending request disagrees with flags");
   chk_key_load: assert property (
      KEY_WE |=> KEY_RDATA == $past(SFR_WDATA))
      else $error("key byte not stored");
   chk_key_drop: assert property (
      PTR_WE || DATA_WE || CFG_WE || ALEN_WE |=> KEY_RDATA == 8'h00)
      else $error("key survives another write");
   chk_ptr_fields: assert property (
      PTR_WE |=> PTR_RDATA == ($past(SFR_WDATA) & 8'h9f))
      else $error("pointer fields wrong");
   chk_rsvd_read: assert property (
      PTR_WE && SFR_WDATA == 8'h00 ##1 !(DATA_WE || PTR_WE)
      |=> DATA_RDATA == 8'h00)
      else $error("reserved location not zero");
   chk_data_store: assert property (
      DATA_WE |=> DATA_RDATA == $past(SFR_WDATA))
      else $error("data byte not stored");
   chk_alen_bits: assert property (
      ALEN_WE |=> ALEN_RDATA == ($past(SFR_WDATA) & 8'h1f))
      else $error("alarm enables wrong");
   chk_alarm_cause: assert property (
      $rose(CFG_RDATA[5]) |-> ($past(ALEN_RDATA) & 8'h1f) != 8'h00)
      else $error("alarm flag with no field enabled");
   chk_ival_cause: assert property (
      $rose(CFG_RDATA[4]) |-> ($past(CFG_RDATA) & 8'h04) != 8'h00)
      else $error("interval flag while disabled");
   chk_cfg_bits: assert property (
      CFG_WE |=> (CFG_RDATA & 8'hcf) == ($past(SFR_WDATA) & 8'h0f))
      else $error("config bits wrong");
endmodule
bind rtcc_core rtcc_sva rtcc_sva_inst (.CLK, .RST, .SFR_WDATA, .PTR_WE,
   .DATA_WE, .KEY_WE, .CFG_WE, .ALEN_WE, .PTR_RDATA, .DATA_RDATA,
   .KEY_RDATA, .CFG_RDATA, .ALEN_RDATA, .RTC_PEND);
`default_nettype wire

/* verif/tb_top.sv */
// tb_top.sv: self-checking bench for rtcc_core
// assumes rtcc_defs.vh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_defs.vh"
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic tick = 1'b0;
   logic [7:0] wd = 8'h00;
   logic [4:0] we = 5'h00;
   wire [7:0] ptr_rd, dat_rd, key_rd, cfg_rd, alen_rd;
   wire pend;
   int err_count = 0;
   int total_checks = 0;
   always #25 clk = ~clk;
   rtcc_core rtcc_core_inst (.CLK(clk), .RST(rst), .TICK_128(tick),
      .SFR_WDATA(wd), .PTR_WE(we[0]), .DATA_WE(we[1]), .KEY_WE(we[2]),
      .CFG_WE(we[3]), .ALEN_WE(we[4]), .PTR_RDATA(ptr_rd),
      .DATA_RDATA(dat_rd), .KEY_RDATA(key_rd), .CFG_RDATA(cfg_rd),
      .ALEN_RDATA(alen_rd), .RTC_PEND(pend));
   task automatic check(input string n, input logic [7:0] s, e);
      total_checks++;
      if (s !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // strobe index: 0 ptr, 1 data, 2 key, 3 cfg, 4 alarm enable
   task automatic sfr(input int k, input logic [7:0] d);
      @(negedge clk);
      wd = d;
      we = 5'h01 << k;
      @(negedge clk);
      we = 5'h00;
   endtask
   // key goes just before the data write so no other strobe can spoil it
   task automatic wreg(input logic [4:0] a, input logic [7:0] d);
      sfr(0, {3'h4, a});
      sfr(2, `RTCC_KEY_TIME);
      sfr(1, d);
   endtask
   task automatic rchk(input string n, input logic [4:0] a,
                       input logic [7:0] e);
      sfr(0, {3'h0, a});
      @(negedge clk);
      check(n, dat_rd, e);
   endtask
   // tick pin held 3 cycles each level to survive the synchroniser
   task automatic pulse(input int n);
      repeat (n) begin
         tick = 1'b1;
         repeat (3) @(negedge clk);
         tick = 1'b0;
         repeat (3) @(negedge clk);
      end
   endtask
   task automatic t_reset;
      for (int a = 0; a < 19; a++)
         rchk("reset", a[4:0], (a == 6 || a == 7) ? 8'h01 : 8'h00);
      check("cfg", cfg_rd, 8'h00);
      check("alen", alen_rd, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_rw;
      for (int a = 0; a < 20; a++)
         wreg(a[4:0], (a == 0 || a == 19) ? 8'h5a : a[7:0]);
      for (int a = 0; a < 20; a++)
         rchk("rw", a[4:0],
              (a == 0 || a == 19) ? 8'h00 : a[7:0]);
      $display("rw test done");
   endtask
   task automatic t_lock;
      sfr(0, {3'h4, `RTCC_A_SEC});
      sfr(1, 8'h33);
      rchk("no key", `RTCC_A_SEC, 8'h02);
      sfr(0, {3'h4, `RTCC_A_XLO});
      sfr(2, `RTCC_KEY_TIME);
      sfr(3, 8'h00);
      sfr(1, 8'h33);
      rchk("key broken", `RTCC_A_XLO, 8'h11);
      sfr(0, {3'h4, `RTCC_A_XHI});
      check("ptr", ptr_rd, {3'h4, `RTCC_A_XHI});
      sfr(2, 8'ha7);
      check("key", key_rd, 8'ha7);
      sfr(1, 8'h33);
      check("key clear", key_rd, 8'h00);
      rchk("wrong key", `RTCC_A_XHI, 8'h12);
      sfr(0, {3'h4, `RTCC_A_WDAY});
      sfr(1, 8'h03);
      rchk("free", `RTCC_A_WDAY, 8'h03);
      $display("lock test done");
   endtask
   task automatic t_roll;
      // month, date, year, then the expected date, month, year
      logic [47:0] c [6] = '{48'h0c1f03010104, 48'h021c041d0204,
         48'h021d04010304, 48'h021c05010305, 48'h041e01010501,
         48'h011e011f0101};
      for (int i = 0; i < 6; i++) begin
         wreg(`RTCC_A_MON, c[i][47:40]);
         wreg(`RTCC_A_MDAY, c[i][39:32]);
         wreg(`RTCC_A_YEAR, c[i][31:24]);
         wreg(`RTCC_A_WDAY, `RTCC_WDAY_MAX);
         wreg(`RTCC_A_HOUR, `RTCC_HOUR_MAX);
         wreg(`RTCC_A_MIN, `RTCC_SEC_MAX);
         wreg(`RTCC_A_SEC, `RTCC_SEC_MAX);
         wreg(`RTCC_A_FRAC, `RTCC_FRAC_MAX);
         pulse(1);
         rchk("date", `RTCC_A_MDAY, c[i][23:16]);
         rchk("month", `RTCC_A_MON, c[i][15:8]);
         rchk("year", `RTCC_A_YEAR, c[i][7:0]);
         rchk("wday", `RTCC_A_WDAY, 8'h00);
      end
      rchk("hour", `RTCC_A_HOUR, 8'h00);
      rchk("min", `RTCC_A_MIN, 8'h00);
      rchk("sec", `RTCC_A_SEC, 8'h00);
      rchk("frac", `RTCC_A_FRAC, 8'h00);
      $display("roll test done");
   endtask
   task automatic t_ival;
      wreg(`RTCC_A_IVAL, 8'hff);
      sfr(3, 8'h0c);
      pulse(254);
      check("early", cfg_rd & 8'h10, 8'h00);
      pulse(1);
      check("iflag", cfg_rd & 8'h10, 8'h10);
      check("pend", {7'h00, pend}, 8'h01);
      wreg(`RTCC_A_IVAL, 8'h01);
      for (int b = 1; b < 4; b++) begin
         sfr(3, 8'h04 | b[7:0]);
         wreg(`RTCC_A_MIN, `RTCC_SEC_MAX);
         wreg(`RTCC_A_SEC, `RTCC_SEC_MAX);
         wreg(`RTCC_A_FRAC, 8'h7e);
         pulse(1);
         check("no event", cfg_rd & 8'h10, 8'h00);
         pulse(1);
         check("event", cfg_rd & 8'h10, 8'h10);
      end
      check("masked", {7'h00, pend}, 8'h00);
      sfr(3, 8'h00);
      $display("interval test done");
   endtask
   task automatic t_alarm;
      logic [7:0] m [5] = '{8'h05, 8'h0a, 8'h0b, 8'h03, 8'h0c};
      for (int f = 1; f < 5; f++)
         wreg(5'h02 + f[4:0], m[f]);
      for (int i = 0; i < 10; i++) begin
         for (int f = 0; f < 5; f++)
            wreg(5'h0a + f[4:0], (f == i % 5) ? 8'h2a : m[f]);
         sfr(4, i < 5 ? 8'h1f : 8'h1f ^ (8'h01 << (i - 5)));
         check("alen", alen_rd,
               i < 5 ? 8'h1f : 8'h1f ^ (8'h01 << (i - 5)));
         sfr(3, 8'h08);
         wreg(`RTCC_A_SEC, 8'h04);
         wreg(`RTCC_A_FRAC, `RTCC_FRAC_MAX);
         pulse(1);
         check("alarm", cfg_rd & 8'h20, i < 5 ? 8'h00 : 8'h20);
         check("apend", {7'h00, pend}, i < 5 ? 8'h00 : 8'h01);
      end
      sfr(3, 8'h08);
      pulse(1);
      check("once", cfg_rd & 8'h20, 8'h00);
      $display("alarm test done");
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge clk);
      rst = 1'b0;
      t_reset;
      t_rw;
      t_lock;
      t_roll;
      t_ival;
      t_alarm;
      complete_run;
   end
   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      $display("Error run expected end seen hang");
      complete_run;
   end
endmodule
`default_nettype wire
